// ### logic/tpw_top.sv
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "tpw_defines.svh"

// How it works
// - 32-bit count advanced through programmable 32-bit prescaler
// - Counts clock, or capture input edges
// - Seven match registers feed six modulated outputs
// - Cycle match resets count, common rate
// - Single-edge output rises on cycle match
// - Double-edge output: two matches set, clear
// - Double edges placed anywhere in cycle
// - Period and width any whole count
// - Released match values apply at cycle boundary
// - Match may interrupt, stop or reset count
// - Modulation off gives plain timer behaviour
// - Capture latches count on input edge
// - External outputs low, high, toggle, keep
module tpw_top
	import tpw_pkg::*;
(
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            nrst,
	// Register port
	input  wire tpw_bus_req_type bus_req,
	output logic          [31:0] rd_data,
	// Pins
	input  wire logic      [3:0] cap_pin,
	output logic           [6:1] pwm_out,
	output logic           [3:0] ext_match,
	// Interrupt
	output logic                 irq
);

	localparam int NM = `TPW_NUM_MATCH;
	localparam int NC = `TPW_NUM_CAP;

	logic [2:0]  ctrl_r;
	logic [2:0]  ctrl_nxt;
	logic [31:0] tc_r;
	logic [31:0] tc_nxt;
	logic [31:0] pr_r;
	logic [31:0] pc_r;
	logic [31:0] pc_nxt;
	logic [3:0]  mode_r;
	logic [20:0] mctl_r;
	logic [11:0] cctl_r;
	logic [11:0] emr_r;
	logic [11:0] emr_nxt;
	logic [14:0] pctl_r;
	logic [6:0]  latch_r;
	logic [6:0]  latch_nxt;
	logic [11:0] stat_r;
	logic [11:0] stat_nxt;
	logic [11:0] mask_r;
	logic [31:0] cap_r [NC];
	logic [31:0] rd_r;
	logic [31:0] rd_nxt;
	logic [6:1]  pwm_r;
	logic [6:1]  pwm_nxt;
	logic [3:0]  cap_s1;
	logic [3:0]  cap_s2;
	logic [3:0]  cap_s3;
	logic [3:0]  cap_lvl_r;
	logic [3:0]  cap_lvl_nxt;

	// Decode
	wire         wr      = bus_req.wr;
	wire  [7:0]  addr    = bus_req.addr;
	wire  [31:0] wdata   = bus_req.wdata;
	wire         wr_stat = wr & (addr == `TPW_OFF_STAT);
	wire         wr_ctrl = wr & (addr == `TPW_OFF_CTRL);
	wire         wr_tc   = wr & (addr == `TPW_OFF_COUNT);
	wire         wr_pr   = wr & (addr == `TPW_OFF_PRE_LIM);
	wire         wr_pc   = wr & (addr == `TPW_OFF_PRE_CNT);
	wire         wr_mode = wr & (addr == `TPW_OFF_MODE);
	wire         wr_mctl = wr & (addr == `TPW_OFF_MCTL);
	wire         wr_cctl = wr & (addr == `TPW_OFF_CCTL);
	wire         wr_emr  = wr & (addr == `TPW_OFF_EXTM);
	wire         wr_pctl = wr & (addr == `TPW_OFF_PCTL);
	wire         wr_lat  = wr & (addr == `TPW_OFF_LATCH);
	wire         wr_mask = wr & (addr == `TPW_OFF_MASK);

	wire         run    = ctrl_r[`TPW_CTRL_RUN];
	wire         clr    = ctrl_r[`TPW_CTRL_CLR];
	wire         pwm_en = ctrl_r[`TPW_CTRL_PWM];

	// Capture pins: a level counts once the second and third stages agree,
	// so a one-cycle glitch never reaches the counter
	assign cap_lvl_nxt = (cap_s2 & cap_s3) | (cap_lvl_r & (cap_s2 | cap_s3));
	wire  [3:0]  cap_rise = cap_lvl_nxt & ~cap_lvl_r;
	wire  [3:0]  cap_fall = ~cap_lvl_nxt & cap_lvl_r;

	// Count source
	wire  [1:0]  src_sel   = mode_r[`TPW_MODE_SEL_POS +: 2];
	wire         src_rise  = cap_rise[src_sel];
	wire         src_fall  = cap_fall[src_sel];
	wire         cnt_timer = (mode_r[1:0] == TPW_CNT_TIMER);
	wire         cnt_edge  = cnt_timer ? 1'b1 :
	                         (mode_r[1:0] == TPW_CNT_RISE) ? src_rise :
	                         (mode_r[1:0] == TPW_CNT_FALL) ? src_fall :
	                         (src_rise | src_fall);
	wire         tick = run & ~clr & cnt_edge;
	wire         adv  = tick & (pc_r == pr_r);

	// Match units
	logic [NM-1:0] hit;
	logic [NM-1:0] wr_mr;
	logic [NM-1:0] m_int;
	logic [NM-1:0] m_rst;
	logic [NM-1:0] m_stop;
	logic [NM-1:0] applied;
	logic [31:0]   mr_shd [NM];

	// Released values move only on the cycle match, so an edge never jumps mid-cycle
	wire boundary = hit[0];

	genvar gi;
	generate
		for (gi = 0; gi < NM; gi++) begin : g_match
			assign wr_mr[gi]   = wr & (addr == 8'(`TPW_OFF_MATCH0 + 4 * gi));
			assign m_int[gi]   = mctl_r[3 * gi + `TPW_MCTL_INT];
			assign m_rst[gi]   = mctl_r[3 * gi + `TPW_MCTL_RST];
			assign m_stop[gi]  = mctl_r[3 * gi + `TPW_MCTL_STOP];
			assign applied[gi] = pwm_en & latch_r[gi] & boundary;
			tpw_match_unit u_match (
				.mclk   (mclk),
				.nrst   (nrst),
				.wr     (wr_mr[gi]),
				.wdata  (wdata),
				.direct (~pwm_en),
				.apply  (applied[gi]),
				.shadow (mr_shd[gi]),
				.adv    (adv),
				.count  (tc_r),
				.hit    (hit[gi])
			);
		end
	endgenerate

	// Cycle match always restarts the count while modulating
	wire reset_any = |(hit & m_rst) | (pwm_en & hit[0]);
	wire stop_any  = |(hit & m_stop);

	assign tc_nxt = wr_tc ? wdata :
	                clr ? `TPW_RST_WORD :
	                !adv ? tc_r :
	                reset_any ? `TPW_RST_WORD : tc_r + 32'h1;
	assign pc_nxt = wr_pc ? wdata :
	                clr ? `TPW_RST_WORD :
	                !tick ? pc_r :
	                adv ? `TPW_RST_WORD : pc_r + 32'h1;

	// A software write in the same cycle as a stop keeps what software wrote
	assign ctrl_nxt = wr_ctrl ? wdata[2:0] :
	                  (ctrl_r & ~({2'h0, stop_any} << `TPW_CTRL_RUN));

	// Release bits: a new set wins over the hardware clear
	assign latch_nxt = (latch_r & ~applied) | (wr_lat ? wdata[6:0] : 7'h00);

	// Modulated outputs; clear wins a tie, so fall match equal to cycle match holds low
	generate
		for (gi = 1; gi <= 6; gi++) begin : g_pwm
			wire dbl  = (gi >= 2) & pctl_r[gi];
			wire on   = pwm_en & pctl_r[`TPW_PCTL_EN_POS + gi];
			wire rise = dbl ? hit[gi - 1] : hit[0];
			assign pwm_nxt[gi] = !on ? 1'b0 :
			                     hit[gi] ? 1'b0 :
			                     rise ? 1'b1 : pwm_r[gi];
		end
	endgenerate

	// External match outputs
	generate
		for (gi = 0; gi < `TPW_NUM_EXT; gi++) begin : g_ext
			wire [1:0] act = emr_r[`TPW_EXTM_ACT_POS + 2 * gi +: 2];
			wire       cur = emr_r[gi];
			assign emr_nxt[gi] = wr_emr ? wdata[gi] :
			                     !hit[gi] ? cur :
			                     (act == TPW_EXT_LOW) ? 1'b0 :
			                     (act == TPW_EXT_HIGH) ? 1'b1 :
			                     (act == TPW_EXT_TOGGLE) ? ~cur : cur;
		end
	endgenerate
	assign emr_nxt[11:4] = wr_emr ? wdata[11:4] : emr_r[11:4];

	// Capture events
	logic [NC-1:0] cap_ev;
	logic [NC-1:0] cap_int;
	generate
		for (gi = 0; gi < NC; gi++) begin : g_cap
			assign cap_ev[gi] = (cctl_r[3 * gi + `TPW_CCTL_RISE] & cap_rise[gi]) |
			                    (cctl_r[3 * gi + `TPW_CCTL_FALL] & cap_fall[gi]);
			assign cap_int[gi] = cap_ev[gi] & cctl_r[3 * gi + `TPW_CCTL_INT];
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					cap_r[gi] <= `TPW_RST_WORD;
				end else if (cap_ev[gi]) begin
					cap_r[gi] <= tc_r;
				end
			end
		end
	endgenerate

	// Sticky status; a new event wins over a write-one clear
	wire [11:0] stat_set = {cap_int, 1'b0, hit & m_int};
	assign stat_nxt = (stat_r & ~(wr_stat ? wdata[11:0] : 12'h000)) | stat_set;
	assign irq = |(stat_r & mask_r);

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (addr)
			`TPW_OFF_STAT:    rd_nxt = {20'h0, stat_r};
			`TPW_OFF_CTRL:    rd_nxt = {29'h0, ctrl_r};
			`TPW_OFF_COUNT:   rd_nxt = tc_r;
			`TPW_OFF_PRE_LIM: rd_nxt = pr_r;
			`TPW_OFF_PRE_CNT: rd_nxt = pc_r;
			`TPW_OFF_MODE:    rd_nxt = {28'h0, mode_r};
			`TPW_OFF_MCTL:    rd_nxt = {11'h0, mctl_r};
			`TPW_OFF_CCTL:    rd_nxt = {20'h0, cctl_r};
			`TPW_OFF_EXTM:    rd_nxt = {20'h0, emr_r};
			`TPW_OFF_PCTL:    rd_nxt = {17'h0, pctl_r};
			`TPW_OFF_LATCH:   rd_nxt = {25'h0, latch_r};
			`TPW_OFF_MASK:    rd_nxt = {20'h0, mask_r};
			default: begin
				for (int i = 0; i < NM; i++) begin
					if (addr == 8'(`TPW_OFF_MATCH0 + 4 * i)) begin
						rd_nxt = mr_shd[i];
					end
				end
				for (int i = 0; i < NC; i++) begin
					if (addr == 8'(`TPW_OFF_CAPT0 + 4 * i)) begin
						rd_nxt = cap_r[i];
					end
				end
			end
		endcase
		if (!bus_req.rd) begin
			rd_nxt = 32'h0000_0000;
		end
	end

	assign rd_data   = rd_r;
	assign pwm_out   = pwm_r;
	assign ext_match = emr_r[3:0];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cap_s1 <= 4'h0;
			cap_s2 <= 4'h0;
			cap_s3 <= 4'h0;
			cap_lvl_r <= 4'h0;
		end else begin
			cap_s1 <= cap_pin;
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
			cap_lvl_r <= cap_lvl_nxt;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r  <= 3'h0;
			tc_r    <= `TPW_RST_WORD;
			pc_r    <= `TPW_RST_WORD;
			latch_r <= 7'h00;
			stat_r  <= 12'h000;
			emr_r   <= 12'h000;
			pwm_r   <= 6'h00;
			rd_r    <= `TPW_RST_WORD;
		end else begin
			ctrl_r  <= ctrl_nxt;
			tc_r    <= tc_nxt;
			pc_r    <= pc_nxt;
			latch_r <= latch_nxt;
			stat_r  <= stat_nxt;
			emr_r   <= emr_nxt;
			pwm_r   <= pwm_nxt;
			rd_r    <= rd_nxt;
		end
	end

	// Plain configuration registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pr_r   <= `TPW_RST_WORD;
			mode_r <= 4'h0;
			mctl_r <= 21'h000000;
			cctl_r <= 12'h000;
			pctl_r <= 15'h0000;
			mask_r <= 12'h000;
		end else begin
			if (wr_pr)   pr_r   <= wdata;
			if (wr_mode) mode_r <= wdata[3:0];
			if (wr_mctl) mctl_r <= wdata[20:0];
			if (wr_cctl) cctl_r <= wdata[11:0];
			if (wr_pctl) pctl_r <= wdata[14:0];
			if (wr_mask) mask_r <= wdata[11:0];
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	prescale_wrap_a: assert property (
		adv && !wr_pc |=> pc_r == 32'h0)
		else $error("prescaler did not wrap at its limit");
	count_step_a: assert property (
		adv && !reset_any && !wr_tc |=> tc_r == $past(tc_r) + 32'h1)
		else $error("count did not step on prescaler wrap");
	cycle_reset_a: assert property (
		pwm_en && hit[0] && !wr_tc |=> tc_r == 32'h0)
		else $error("cycle match did not restart count");
	match_stop_a: assert property (
		stop_any && !wr_ctrl |=> !run ##1 tc_r == $past(tc_r))
		else $error("stop on match did not halt count");
	edge_hold_a: assert property (
		!cnt_timer && !src_rise && !src_fall && !clr && !wr_tc |=> tc_r == $past(tc_r))
		else $error("counter mode moved without a pin edge");
	capture_latch_a: assert property (
		cap_ev[0] |=> cap_r[0] == $past(tc_r))
		else $error("capture did not latch count");
	release_apply_a: assert property (
		pwm_en && latch_r[1] && hit[0] && !wr_lat |=> !latch_r[1])
		else $error("release bit not consumed at boundary");
	single_rise_a: assert property (
		pwm_en && pctl_r[`TPW_PCTL_EN_POS + 1] && hit[0] && !hit[1] |=> pwm_out[1])
		else $error("single-edge output did not rise");
	double_fall_a: assert property (
		pctl_r[2] && hit[2] |=> !pwm_out[2] ##1 1'b1)
		else $error("double-edge output did not fall");
	ext_toggle_a: assert property (
		hit[0] && !wr_emr && emr_r[5:4] == TPW_EXT_TOGGLE |=> ext_match[0] != $past(ext_match[0]))
		else $error("external output did not toggle");
	match_irq_a: assert property (
		hit[0] && m_int[0] && mask_r[0] && !wr_mask |=> irq)
		else $error("match interrupt not raised");

endmodule

`default_nettype wire

// ### pkg/tpw_defines.svh
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

// Register offsets
`define TPW_OFF_STAT     8'h00
`define TPW_OFF_CTRL     8'h04
`define TPW_OFF_COUNT    8'h08
`define TPW_OFF_PRE_LIM  8'h0c
`define TPW_OFF_PRE_CNT  8'h10
`define TPW_OFF_MODE     8'h14
`define TPW_OFF_MCTL     8'h18
`define TPW_OFF_MATCH0   8'h1c
`define TPW_OFF_CCTL     8'h38
`define TPW_OFF_CAPT0    8'h3c
`define TPW_OFF_EXTM     8'h4c
`define TPW_OFF_PCTL     8'h50
`define TPW_OFF_LATCH    8'h54
`define TPW_OFF_MASK     8'h58

// Sizes
`define TPW_NUM_MATCH    7
`define TPW_NUM_CAP      4
`define TPW_NUM_EXT      4

// Control fields
`define TPW_CTRL_RUN     0
`define TPW_CTRL_CLR     1
`define TPW_CTRL_PWM     2

// Per-match control: three bits each
`define TPW_MCTL_INT     0
`define TPW_MCTL_RST     1
`define TPW_MCTL_STOP    2

// Per-capture control: three bits each
`define TPW_CCTL_RISE    0
`define TPW_CCTL_FALL    1
`define TPW_CCTL_INT     2

// Field positions
`define TPW_STAT_CAP_POS 8
`define TPW_EXTM_ACT_POS 4
`define TPW_PCTL_EN_POS  8
`define TPW_MODE_SEL_POS 2

// Reset values
`define TPW_RST_WORD     32'h0000_0000

`endif

// ### pkg/tpw_pkg.sv
`default_nettype none

package tpw_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tpw_bus_req_type;

	typedef enum logic [1:0] {
		TPW_CNT_TIMER = 2'h0,
		TPW_CNT_RISE  = 2'h1,
		TPW_CNT_FALL  = 2'h2,
		TPW_CNT_BOTH  = 2'h3
	} tpw_cnt_mode_type;

	typedef enum logic [1:0] {
		TPW_EXT_KEEP   = 2'h0,
		TPW_EXT_LOW    = 2'h1,
		TPW_EXT_HIGH   = 2'h2,
		TPW_EXT_TOGGLE = 2'h3
	} tpw_ext_act_type;

endpackage

`default_nettype wire

// ### logic/tpw_match_unit.sv
`timescale 1ns/1ps
`default_nettype none

`include "tpw_defines.svh"

module tpw_match_unit
	import tpw_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Software side
	input  wire logic        wr,
	input  wire logic [31:0] wdata,
	input  wire logic        direct,
	input  wire logic        apply,
	output logic      [31:0] shadow,
	// Counter side
	input  wire logic        adv,
	input  wire logic [31:0] count,
	output logic             hit
);

	logic [31:0] shd_r;
	logic [31:0] shd_nxt;
	logic [31:0] act_r;
	logic [31:0] act_nxt;

	assign shd_nxt = wr ? wdata : shd_r;
	// Without modulation the value takes effect at once; otherwise it waits for release
	assign act_nxt = direct ? shd_nxt : (apply ? shd_r : act_r);
	assign hit     = adv & (count == act_r);
	assign shadow  = shd_r;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shd_r <= `TPW_RST_WORD;
			act_r <= `TPW_RST_WORD;
		end else begin
			shd_r <= shd_nxt;
			act_r <= act_nxt;
		end
	end

endmodule

`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "tpw_defines.svh"

module tb_top
	import tpw_pkg::*;
;
	logic            mclk;
	logic            nrst;
	tpw_bus_req_type bus_req;
	logic     [31:0] rd_data;
	logic      [3:0] cap_pin;
	logic      [6:1] pwm_out;
	logic      [3:0] ext_match;
	logic            irq;
	int              fails;
	int              checks_done;
	logic     [31:0] d;
	int              n;
	int              m;

	tpw_top dut (
		.mclk      (mclk),
		.nrst      (nrst),
		.bus_req   (bus_req),
		.rd_data   (rd_data),
		.cap_pin   (cap_pin),
		.pwm_out   (pwm_out),
		.ext_match (ext_match),
		.irq       (irq)
	);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask

	// Data is only valid in the cycle right after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1;
		v = rd_data;
	endtask

	// High cycles of one output over four 10-count periods
	task automatic hi_cnt(input int idx, output int k);
		k = 0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			if ($isunknown(pwm_out[idx])) k += 1000;
			else k += pwm_out[idx];
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic t_reset;
		check(rd_data, 32'h0000_0000);
		check(pwm_out, 6'h00);
		check({ext_match, irq}, 5'h00);
		rd(`TPW_OFF_CTRL, d);
		check(d, 32'h0000_0000);
		wr(8'hfc, 32'h1234_5678);
		rd(8'hfc, d);
		check(d, 32'h0000_0000);
		wr(`TPW_OFF_CAPT0, 32'h0000_00ff);
		rd(`TPW_OFF_CAPT0, d);
		check(d, 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_stop_irq;
		wr(`TPW_OFF_PRE_LIM, 32'h0000_0002);
		wr(`TPW_OFF_MATCH0, 32'h0000_0005);
		wr(`TPW_OFF_MCTL, 32'h0000_0005);
		wr(`TPW_OFF_MASK, 32'h0000_0001);
		wr(`TPW_OFF_CTRL, 32'h0000_0001);
		repeat (40) @(posedge mclk);
		// The match is seen on the step that leaves 5, so the count halts one past it
		rd(`TPW_OFF_COUNT, d);
		check(d, 32'h0000_0006);
		rd(`TPW_OFF_PRE_CNT, d);
		check(d, 32'h0000_0000);
		rd(`TPW_OFF_CTRL, d);
		check(d[0], 1'b0);
		check(irq, 1'b1);
		wr(`TPW_OFF_MASK, 32'h0000_0000);
		#1;
		check(irq, 1'b0);
		wr(`TPW_OFF_MASK, 32'h0000_0001);
		wr(`TPW_OFF_STAT, 32'h0000_0001);
		#1;
		check(irq, 1'b0);
		rd(`TPW_OFF_STAT, d);
		check(d[0], 1'b0);
		$display("test stop and interrupt done");
	endtask

	task automatic t_reset_ext;
		wr(`TPW_OFF_CTRL, 32'h0000_0002);
		wr(`TPW_OFF_PRE_LIM, 32'h0000_0000);
		wr(`TPW_OFF_MATCH0, 32'h0000_0003);
		wr(`TPW_OFF_MATCH0 + 8'h04, 32'h0000_0001);
		wr(`TPW_OFF_MATCH0 + 8'h08, 32'h0000_0002);
		wr(`TPW_OFF_MATCH0 + 8'h0c, 32'h0000_0003);
		wr(`TPW_OFF_MCTL, 32'h0000_0002);
		// Out0 toggle, out1 high, out2 low from 1, out3 keep at 1
		wr(`TPW_OFF_EXTM, 32'h0000_01bc);
		wr(`TPW_OFF_CTRL, 32'h0000_0001);
		repeat (8) begin
			rd(`TPW_OFF_COUNT, d);
			check(d <= 32'h0000_0003, 1'b1);
		end
		// Any 40 edges hold exactly ten cycle matches of a 4-count period
		n = 0;
		m = ext_match[0];
		repeat (40) begin
			@(posedge mclk);
			#1;
			if (ext_match[0] !== m[0]) n++;
			m = ext_match[0];
		end
		check(n, 10);
		check(ext_match[3:1], 3'b101);
		$display("test reset on match and outputs done");
	endtask

	task automatic t_pwm;
		wr(`TPW_OFF_CTRL, 32'h0000_0002);
		wr(`TPW_OFF_MCTL, 32'h0000_0000);
		wr(`TPW_OFF_MATCH0, 32'h0000_0009);
		wr(`TPW_OFF_MATCH0 + 8'h04, 32'h0000_0004);
		wr(`TPW_OFF_MATCH0 + 8'h08, 32'h0000_0008);
		wr(`TPW_OFF_LATCH, 32'h0000_0007);
		wr(`TPW_OFF_PCTL, 32'h0000_0604);
		wr(`TPW_OFF_CTRL, 32'h0000_0005);
		repeat (30) @(posedge mclk);
		hi_cnt(1, n);
		check(n, 20);
		hi_cnt(2, n);
		check(n, 16);
		check(pwm_out[6:3], 4'h0);
		wr(`TPW_OFF_MATCH0 + 8'h04, 32'h0000_0007);
		repeat (30) @(posedge mclk);
		hi_cnt(1, n);
		check(n, 20);
		wr(`TPW_OFF_LATCH, 32'h0000_0002);
		repeat (30) @(posedge mclk);
		hi_cnt(1, n);
		check(n, 32);
		hi_cnt(2, n);
		check(n, 4);
		wr(`TPW_OFF_MATCH0 + 8'h04, 32'h0000_0004);
		wr(`TPW_OFF_MATCH0 + 8'h08, 32'h0000_0002);
		wr(`TPW_OFF_LATCH, 32'h0000_0006);
		repeat (30) @(posedge mclk);
		hi_cnt(2, n);
		check(n, 32);
		hi_cnt(1, n);
		check(n, 20);
		$display("test modulation done");
	endtask

	task automatic t_counter_capture;
		wr(`TPW_OFF_CTRL, 32'h0000_0002);
		wr(`TPW_OFF_MODE, 32'h0000_0001);
		// Capture 0 on falling edges, capture 1 on rising edges with interrupt
		wr(`TPW_OFF_CCTL, 32'h0000_002a);
		wr(`TPW_OFF_MASK, 32'h0000_0200);
		wr(`TPW_OFF_STAT, 32'h0000_0fff);
		wr(`TPW_OFF_CTRL, 32'h0000_0001);
		// Wide pulses: the pin synchroniser drops only a one-cycle pulse
		repeat (5) begin
			@(posedge mclk);
			cap_pin[0] <= 1'b1;
			repeat (4) @(posedge mclk);
			cap_pin[0] <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
		rd(`TPW_OFF_COUNT, d);
		check(d, 32'h0000_0005);
		check(irq, 1'b0);
		@(posedge mclk);
		cap_pin[1] <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(`TPW_OFF_CAPT0 + 8'h04, d);
		check(d, 32'h0000_0005);
		check(irq, 1'b1);
		// Falling edges of pin 1, then both edges of pin 0
		wr(`TPW_OFF_MODE, 32'h0000_0006);
		cap_pin[1] <= 1'b0;
		repeat (8) @(posedge mclk);
		wr(`TPW_OFF_MODE, 32'h0000_0003);
		cap_pin[0] <= 1'b1;
		repeat (8) @(posedge mclk);
		cap_pin[0] <= 1'b0;
		repeat (8) @(posedge mclk);
		rd(`TPW_OFF_COUNT, d);
		check(d, 32'h0000_0008);
		// The fall latches the count of its own cycle, before that cycle's step
		rd(`TPW_OFF_CAPT0, d);
		check(d, 32'h0000_0007);
		$display("test counter and capture done");
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		tally_and_finish();
	end

	initial begin
		fails = 0;
		checks_done = 0;
		nrst = 1'b0;
		bus_req = '0;
		cap_pin = 4'h0;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		t_reset();
		t_stop_irq();
		t_reset_ext();
		t_pwm();
		t_counter_capture();
		tally_and_finish();
	end
endmodule

`default_nettype wire
